// ---- lic_pkg.sv ----
/*
  constants for the line interface control register bank: offsets, field
  positions, reset values and code tables.
  assumes an 8-bit register port with byte-wide data and 4-bit addresses.
*/
package lic_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] OFS_LINE_OUTPUT_POWER_CONTROL = 4'h6;
  localparam logic [3:0] OFS_RESERVED_SLOT_SEVEN = 4'h7;
  localparam logic [3:0] OFS_RESERVED_SLOT_EIGHT = 4'h8;
  localparam logic [3:0] OFS_LINE_SAMPLE_RATE_SELECT = 4'h9;
  localparam logic [3:0] OFS_RESERVED_SLOT_TEN = 4'hA;
  localparam logic [3:0] OFS_SYSTEM_MODULE_REVISION = 4'hB;

  // field positions in line_output_power_control
  localparam int BIT_TX_HI = 6;
  localparam int BIT_TX_LO = 1;
  localparam int BIT_RX_HI = 5;
  localparam int BIT_RX_LO = 0;
  localparam int BIT_LINE_SLEEP = 4;
  localparam int BIT_SYS_SLEEP = 3;

  // reset values
  localparam logic [7:0] RST_LINE_OUTPUT_POWER_CONTROL = 8'h00;
  localparam logic [2:0] RST_SAMPLE_RATE_CODE = 3'h0;

  // monitor transmit level codes
  localparam logic [1:0] TX_M20DB = 2'h0;
  localparam logic [1:0] TX_M32DB = 2'h1;
  localparam logic [1:0] TX_MUTE = 2'h2;
  localparam logic [1:0] TX_M26DB = 2'h3;
  // monitor receive level codes
  localparam logic [1:0] RX_0DB = 2'h0;
  localparam logic [1:0] RX_M12DB = 2'h1;
  localparam logic [1:0] RX_MUTE = 2'h2;
  localparam logic [1:0] RX_M6DB = 2'h3;
  // attenuation in dB handed to the monitor mixer, 6'h3F means mute
  localparam logic [5:0] ATT_MUTE = 6'h3F;
  localparam logic [5:0] ATT_0DB = 6'h00;
  localparam logic [5:0] ATT_6DB = 6'h06;
  localparam logic [5:0] ATT_12DB = 6'h0C;
  localparam logic [5:0] ATT_20DB = 6'h14;
  localparam logic [5:0] ATT_26DB = 6'h1A;
  localparam logic [5:0] ATT_32DB = 6'h20;

  // sample rate codes and rates in Hz
  localparam logic [2:0] SR_7200 = 3'h0;
  localparam logic [2:0] SR_8000 = 3'h1;
  localparam logic [2:0] SR_8229 = 3'h2;
  localparam logic [2:0] SR_8400 = 3'h3;
  localparam logic [2:0] SR_9000 = 3'h4;
  localparam logic [2:0] SR_9600 = 3'h5;
  localparam logic [13:0] HZ_7200 = 14'h1C20;
  localparam logic [13:0] HZ_8000 = 14'h1F40;
  localparam logic [13:0] HZ_8229 = 14'h2025;
  localparam logic [13:0] HZ_8400 = 14'h20D0;
  localparam logic [13:0] HZ_9000 = 14'h2328;
  localparam logic [13:0] HZ_9600 = 14'h2580;

  // arbitrary neutral revision value
  localparam logic [3:0] DEFAULT_REV = 4'h1;
endpackage

// ---- lic_regs.sv ----
/*
  line interface control register bank: monitor output levels, sleep
  controls, line sample rate and system module revision.
  assumes a single-cycle register port: strobes one cycle wide, read data
  valid in the cycle after the read strobe; everything on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module lic_regs #(
  parameter logic [3:0] SYS_REV = lic_pkg::DEFAULT_REV
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic sys_module_reset_i,
  output logic [7:0] reg_rdata_o,
  output logic [1:0] monitor_tx_level_o,
  output logic [1:0] monitor_rx_level_o,
  output logic [5:0] call_progress_out_tx_att_o,
  output logic call_progress_out_tx_mute_o,
  output logic [5:0] call_progress_out_rx_att_o,
  output logic call_progress_out_rx_mute_o,
  output logic line_chip_sleep_o,
  output logic system_module_sleep_o,
  output logic [2:0] sample_rate_code_o,
  output logic [13:0] sample_rate_hz_o,
  output logic sample_rate_code_bad_o
);

  initial begin
    if (SYS_REV > 4'hF) begin
      $error("revision value does not fit four bits");
    end
  end

  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] tx_level;
    logic [1:0] rx_level;
    logic line_sleep;
    logic sys_sleep_bit;
    logic sys_down;
    logic [2:0] rate_code;
    logic [5:0] tx_att;
    logic tx_mute;
    logic [5:0] rx_att;
    logic rx_mute;
    logic [13:0] rate_hz;
    logic rate_bad;
  } lic_state_t;

  lic_state_t state;
  lic_state_t next_state;

  // transmit monitor attenuation; mute carried as a separate flag
  function automatic logic [6:0] lic_tx_att(input logic [1:0] code);
    case (code)
      lic_pkg::TX_M20DB: lic_tx_att = {1'b0, lic_pkg::ATT_20DB};
      lic_pkg::TX_M32DB: lic_tx_att = {1'b0, lic_pkg::ATT_32DB};
      lic_pkg::TX_MUTE: lic_tx_att = {1'b1, lic_pkg::ATT_MUTE};
      lic_pkg::TX_M26DB: lic_tx_att = {1'b0, lic_pkg::ATT_26DB};
      default: lic_tx_att = {1'b1, lic_pkg::ATT_MUTE};
    endcase
  endfunction

  // receive monitor attenuation
  function automatic logic [6:0] lic_rx_att(input logic [1:0] code);
    case (code)
      lic_pkg::RX_0DB: lic_rx_att = {1'b0, lic_pkg::ATT_0DB};
      lic_pkg::RX_M12DB: lic_rx_att = {1'b0, lic_pkg::ATT_12DB};
      lic_pkg::RX_MUTE: lic_rx_att = {1'b1, lic_pkg::ATT_MUTE};
      lic_pkg::RX_M6DB: lic_rx_att = {1'b0, lic_pkg::ATT_6DB};
      default: lic_rx_att = {1'b1, lic_pkg::ATT_MUTE};
    endcase
  endfunction

  // sample rate decode; unlisted codes flag bad and hold 8000 Hz
  function automatic logic [14:0] lic_rate(input logic [2:0] code);
    case (code)
      lic_pkg::SR_7200: lic_rate = {1'b0, lic_pkg::HZ_7200};
      lic_pkg::SR_8000: lic_rate = {1'b0, lic_pkg::HZ_8000};
      lic_pkg::SR_8229: lic_rate = {1'b0, lic_pkg::HZ_8229};
      lic_pkg::SR_8400: lic_rate = {1'b0, lic_pkg::HZ_8400};
      lic_pkg::SR_9000: lic_rate = {1'b0, lic_pkg::HZ_9000};
      lic_pkg::SR_9600: lic_rate = {1'b0, lic_pkg::HZ_9600};
      default: lic_rate = {1'b1, lic_pkg::HZ_8000};
    endcase
  endfunction

  // next-state logic: register writes, sleep latch, read mux
  always_comb begin
    logic [6:0] tx_dec;
    logic [6:0] rx_dec;
    logic [14:0] rate_dec;
    tx_dec = 7'h00;
    rx_dec = 7'h00;
    rate_dec = 15'h0000;
    next_state = state;

    if (reg_wr_i && reg_addr_i == lic_pkg::OFS_LINE_OUTPUT_POWER_CONTROL) begin
      // bits 7 and 2 are dropped on write
      next_state.tx_level = {reg_wdata_i[lic_pkg::BIT_TX_HI], reg_wdata_i[lic_pkg::BIT_TX_LO]};
      next_state.rx_level = {reg_wdata_i[lic_pkg::BIT_RX_HI], reg_wdata_i[lic_pkg::BIT_RX_LO]};
      next_state.line_sleep = reg_wdata_i[lic_pkg::BIT_LINE_SLEEP];
      next_state.sys_sleep_bit = reg_wdata_i[lic_pkg::BIT_SYS_SLEEP];
    end
    if (reg_wr_i && reg_addr_i == lic_pkg::OFS_LINE_SAMPLE_RATE_SELECT) begin
      next_state.rate_code = reg_wdata_i[2:0];
    end

    // power-down latches; clearing the bit alone does not wake the module
    if (next_state.sys_sleep_bit) begin
      next_state.sys_down = 1'b1;
    end else if (sys_module_reset_i) begin
      next_state.sys_down = 1'b0;
    end

    // decoded levels drive only the monitor mixer, never the main paths
    tx_dec = lic_tx_att(next_state.tx_level);
    rx_dec = lic_rx_att(next_state.rx_level);
    next_state.tx_mute = tx_dec[6];
    next_state.tx_att = tx_dec[5:0];
    next_state.rx_mute = rx_dec[6];
    next_state.rx_att = rx_dec[5:0];
    rate_dec = lic_rate(next_state.rate_code);
    next_state.rate_bad = rate_dec[14];
    next_state.rate_hz = rate_dec[13:0];

    // read data valid only in the cycle after the strobe
    next_state.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        lic_pkg::OFS_LINE_OUTPUT_POWER_CONTROL: begin
          next_state.rdata = {1'b0, state.tx_level[1], state.rx_level[1], state.line_sleep,
                              state.sys_sleep_bit, 1'b0, state.tx_level[0], state.rx_level[0]};
        end
        lic_pkg::OFS_LINE_SAMPLE_RATE_SELECT: begin
          next_state.rdata = {5'h00, state.rate_code};
        end
        lic_pkg::OFS_SYSTEM_MODULE_REVISION: begin
          next_state.rdata = {4'h0, SYS_REV};
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
  end

  // single state register; synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state <= '0;
      state.tx_level <= {lic_pkg::RST_LINE_OUTPUT_POWER_CONTROL[lic_pkg::BIT_TX_HI],
                         lic_pkg::RST_LINE_OUTPUT_POWER_CONTROL[lic_pkg::BIT_TX_LO]};
      state.rx_level <= {lic_pkg::RST_LINE_OUTPUT_POWER_CONTROL[lic_pkg::BIT_RX_HI],
                         lic_pkg::RST_LINE_OUTPUT_POWER_CONTROL[lic_pkg::BIT_RX_LO]};
      state.rate_code <= lic_pkg::RST_SAMPLE_RATE_CODE;
      state.tx_att <= lic_pkg::ATT_20DB;
      state.rx_att <= lic_pkg::ATT_0DB;
      state.rate_hz <= lic_pkg::HZ_7200;
    end else begin
      state <= next_state;
    end
  end

  // outputs all straight from flip-flops
  assign reg_rdata_o = state.rdata;
  assign monitor_tx_level_o = state.tx_level;
  assign monitor_rx_level_o = state.rx_level;
  assign call_progress_out_tx_att_o = state.tx_att;
  assign call_progress_out_tx_mute_o = state.tx_mute;
  assign call_progress_out_rx_att_o = state.rx_att;
  assign call_progress_out_rx_mute_o = state.rx_mute;
  assign line_chip_sleep_o = state.line_sleep;
  assign system_module_sleep_o = state.sys_down;
  assign sample_rate_code_o = state.rate_code;
  assign sample_rate_hz_o = state.rate_hz;
  assign sample_rate_code_bad_o = state.rate_bad;

endmodule
`default_nettype wire

// ---- lic_regs_props.sv ----
/* port checker for the line interface control register bank.
  assumes one mclk_i domain and a synchronous active-low rst_b_i. */
`timescale 1ns/100ps
`default_nettype none
module lic_regs_props (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic sys_module_reset_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] monitor_tx_level_o,
  input wire logic [1:0] monitor_rx_level_o,
  input wire logic line_chip_sleep_o,
  input wire logic system_module_sleep_o,
  input wire logic [2:0] sample_rate_code_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // write strobes of the two writable registers
  sequence s_wr6; reg_wr_i && reg_addr_i == 4'h6; endsequence
  sequence s_wr9; reg_wr_i && reg_addr_i == 4'h9; endsequence
  property p_tx; s_wr6 |=> monitor_tx_level_o == {$past(reg_wdata_i[6]), $past(reg_wdata_i[1])}; endproperty
  property p_rx; s_wr6 |=> monitor_rx_level_o == {$past(reg_wdata_i[5]), $past(reg_wdata_i[0])}; endproperty
  property p_line; s_wr6 |=> line_chip_sleep_o == $past(reg_wdata_i[4]); endproperty
  property p_sys_set; s_wr6 ##0 reg_wdata_i[3] |=> system_module_sleep_o; endproperty
  // the module only wakes through its own reset, never through a plain write
  property p_sys_hold; system_module_sleep_o && !sys_module_reset_i |=> system_module_sleep_o; endproperty
  property p_rate; s_wr9 |=> sample_rate_code_o == $past(reg_wdata_i[2:0]); endproperty
  property p_rsvd; reg_rd_i && reg_addr_i inside {4'h7, 4'h8, 4'hA} |=> reg_rdata_o == 8'h00; endproperty
  property p_ign; !(reg_wr_i && reg_addr_i == 4'h6) |=> $stable(monitor_tx_level_o) && $stable(line_chip_sleep_o);
  endproperty
  property p_rev; reg_rd_i && reg_addr_i == 4'hB |=> reg_rdata_o[7:4] == 4'h0; endproperty
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rev: assert property (p_rev) else $error("revision upper bits");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_tx: assert property (p_tx) else $error("tx level");
  a_rx: assert property (p_rx) else $error("rx level");
  a_line: assert property (p_line) else $error("line sleep");
  a_sys_set: assert property (p_sys_set) else $error("sys sleep set");
  a_sys_hold: assert property (p_sys_hold) else $error("sys sleep hold");
  a_rate: assert property (p_rate) else $error("rate code");
  a_rsvd: assert property (p_rsvd) else $error("reserved read");
  a_ign: assert property (p_ign) else $error("stray write");
endmodule
bind lic_regs lic_regs_props lic_regs_props_i (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .sys_module_reset_i, .reg_rdata_o, .monitor_tx_level_o, .monitor_rx_level_o, .line_chip_sleep_o,
  .system_module_sleep_o, .sample_rate_code_o);
`default_nettype wire

// ---- tb.sv ----
/* self-checking bench for lic_regs: random and corner register traffic.
  assumes the checker file is compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [3:0] REV = 4'h9; // arbitrary revision value
  logic mclk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sys_module_reset_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic [1:0] monitor_tx_level_o, monitor_rx_level_o;
  logic [5:0] call_progress_out_tx_att_o, call_progress_out_rx_att_o;
  logic call_progress_out_tx_mute_o, call_progress_out_rx_mute_o, line_chip_sleep_o, system_module_sleep_o;
  logic [2:0] sample_rate_code_o;
  logic [13:0] sample_rate_hz_o;
  logic sample_rate_code_bad_o;
  logic [3:0] rsv [5] = '{4'h7, 4'h8, 4'hA, 4'hB, 4'hF};
  int seed = 1, err_total = 0, checks = 0;
  lic_regs #(.SYS_REV(REV)) lic_regs_i (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .sys_module_reset_i, .reg_rdata_o, .monitor_tx_level_o, .monitor_rx_level_o, .call_progress_out_tx_att_o,
    .call_progress_out_tx_mute_o, .call_progress_out_rx_att_o, .call_progress_out_rx_mute_o, .line_chip_sleep_o,
    .system_module_sleep_o, .sample_rate_code_o, .sample_rate_hz_o, .sample_rate_code_bad_o);
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  // expected attenuation and rate tables
  function automatic logic [5:0] att(input logic [1:0] c, input logic tx);
    return c == 2'h2 ? 6'h3F : tx ? (c == 2'h0 ? 6'h14 : c == 2'h1 ? 6'h20 : 6'h1A) :
      (c == 2'h0 ? 6'h00 : c == 2'h1 ? 6'h0C : 6'h06);
  endfunction
  function automatic logic [13:0] hz(input logic [2:0] c);
    logic [13:0] t [8] = '{14'h1C20, 14'h1F40, 14'h2025, 14'h20D0, 14'h2328, 14'h2580, 14'h1F40, 14'h1F40};
    return t[c];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one-cycle strobes, launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about 170 cycles
  initial begin
    repeat (3000) @(posedge mclk_i);
    err_total++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 chk(sample_rate_hz_o, 14'h1C20);
    rdc(4'h6, 8'h00);
    for (int i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      if (i < 16) {d[6], d[1], d[5], d[0]} = i[3:0];
      wr(4'h6, d);
      chk({call_progress_out_tx_mute_o, call_progress_out_tx_att_o, monitor_tx_level_o}, {{d[6], d[1]} == 2'h2, att({d[6], d[1]}, 1'b1), d[6], d[1]});
      chk({call_progress_out_rx_mute_o, call_progress_out_rx_att_o, monitor_rx_level_o}, {{d[5], d[0]} == 2'h2, att({d[5], d[0]}, 1'b0), d[5], d[0]});
      chk(line_chip_sleep_o, d[4]);
      rdc(4'h6, d & 8'h7B);
    end
    $display("level test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(4'h9, {d[7:3], i[2:0]});
      chk({sample_rate_code_bad_o, sample_rate_hz_o, sample_rate_code_o}, {i > 5, hz(i[2:0]), i[2:0]});
      rdc(4'h9, {5'h00, i[2:0]});
    end
    $display("rate test done");
    wr(4'h6, 8'h10);
    chk(line_chip_sleep_o, 1'b1);
    wr(4'h9, 8'h07); // rate set up before the line chip is woken
    wr(4'h6, 8'h08);
    chk(line_chip_sleep_o, 1'b0);
    chk(system_module_sleep_o, 1'b1);
    wr(4'h6, 8'h52);
    chk(system_module_sleep_o, 1'b1);
    @(posedge mclk_i);
    sys_module_reset_i <= 1'b1;
    @(posedge mclk_i);
    sys_module_reset_i <= 1'b0;
    #1 chk(system_module_sleep_o, 1'b0);
    $display("sleep test done");
    foreach (rsv[k]) begin
      wr(rsv[k], 8'hFF);
      rdc(rsv[k], rsv[k] == 4'hB ? {4'h0, REV} : 8'h00);
    end
    rdc(4'h6, 8'h52);
    rdc(4'h9, 8'h07);
    $display("reserved test done");
    close_out;
  end
endmodule
`default_nettype wire
